/* design/pcirq_pkg.sv */
// package of the pin-change and external interrupt flag block
// assumes one 100 MHz system clock and a plain register port with 8-bit data
package pcirq_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_ENABLE = 8'h1d;
  localparam logic [7:0] ADDR_FLAGS  = 8'h1c;
  localparam logic [7:0] ADDR_SENSE  = 8'h69;
  localparam logic [7:0] ADDR_MASK0  = 8'h6b;
  localparam logic [7:0] ADDR_MASK1  = 8'h6c;
  localparam logic [7:0] ADDR_MASK2  = 8'h6d;
  localparam logic [7:0] ADDR_MASK3  = 8'h73;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int BIT_EXT0      = 0;
  localparam int BIT_GROUP0    = 4;
  localparam int NUM_GROUPS    = 4;
  localparam int GROUP_WIDTH   = 8;
  localparam int NUM_PINS      = 31;
  localparam int SENSE_WIDTH   = 2;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [7:0] MASK3_USED     = 8'h7f;
  localparam logic [7:0] FLAG_USED_BIG  = 8'hf1;
  localparam logic [7:0] FLAG_USED_SMAL = 8'h31;
  localparam int NUM_VECTORS   = 5;

  // ****************************************
  // sense modes of external pin zero
  // ****************************************
  typedef enum logic [1:0] {
    SENSE_LOW     = 2'h0,
    SENSE_CHANGE  = 2'h1,
    SENSE_FALLING = 2'h2,
    SENSE_RISING  = 2'h3
  } sense_mode_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // vector order: 0 ext pin zero, 1..4 pin-change groups 0..3
  typedef struct packed {
    logic [NUM_VECTORS-1:0] request;
    logic [NUM_VECTORS-1:0] serviced;
  } vector_if_t;

endpackage

/* design/pcirq_edge_detect.sv */
// sample register and change detector for the pin-change inputs
// assumes inputs already synchronous to the system clock
`timescale 1ns/1ps
module pcirq_edge_detect #(
  parameter int WIDTH = 32
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pins,
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_change
);

  typedef struct packed {
    logic [WIDTH-1:0] cur;
    logic [WIDTH-1:0] prev;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ****************************************
  // sample and compare
  // ****************************************
  always_comb begin
    state_next      = state_reg;
    state_next.cur  = i_pins;
    state_next.prev = state_reg.cur;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_level  = state_reg.cur;
  assign o_change = state_reg.cur ^ state_reg.prev; // [RULE18]

endmodule

/* design/pcirq_flags.sv */
// pin-change and external pin zero interrupt flags with masks and enables
// assumes the core drives a one-cycle serviced pulse per vector it enters
`timescale 1ns/1ps
// Operation
// [RULE1] change on enabled pin of inputs 15..8 sets group 1 flag
// [RULE2] change on enabled pin of inputs 7..0 sets group 0 flag
// [RULE3] selected event on external pin zero sets flag bit 0
// [RULE4] vector request needs flag, global enable and source enable
// [RULE5] flag clears when the core enters its vector
// [RULE6] writing one clears a flag, zero leaves it
// [RULE7] in low-level sense the pin zero flag stays zero
// [RULE8] mask 3 bits 6:0 enable inputs 30..24 under group 3 enable
// [RULE9] mask 2 bits enable inputs 23..16 under group 2 enable
// [RULE10] mask 1 bits enable inputs 15..8 under group 1 enable
// [RULE11] mask 0 bits enable inputs 7..0 under group 0 enable
// [RULE12] a cleared mask bit blocks its pin whatever the group enable
// [RULE13] small variant drops masks 3, 2 and groups 3, 2
// [RULE14] sense codes: 00 low, 01 change, 10 falling, 11 rising
// [RULE15] enable reg: group enables bits 7..4, pin zero enable bit 0
// [RULE16] group 3 flag at bit 7, group 2 flag at bit 6
// [RULE17] detection works even while the pin is driven as output
// [RULE18] change found by comparing current sample with previous
// [RULE19] flags and masks reset to zero, reserved bits read zero
module pcirq_flags #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                            i_clk_sys,
  input  wire logic                            i_rst,
  input  wire pcirq_pkg::reg_req_t             i_req,
  output logic      [7:0]                      o_rdata,
  input  wire logic [pcirq_pkg::NUM_PINS-1:0]  i_change_input_pins,
  input  wire logic                            i_ext_irq_pin_zero,
  input  wire logic                            i_global_irq_enable,
  input  wire logic [pcirq_pkg::NUM_VECTORS-1:0] i_serviced,
  output logic      [pcirq_pkg::NUM_VECTORS-1:0] o_request,
  output logic                                 o_ext_pin_level_req
);

  localparam int NG = pcirq_pkg::NUM_GROUPS;
  localparam int GW = pcirq_pkg::GROUP_WIDTH;

  typedef struct packed {
    logic [NG-1:0][GW-1:0] mask;
    logic [NG-1:0]         group_enable;
    logic                  ext0_enable;
    logic [NG-1:0]         group_flag;
    logic                  ext0_flag;
    logic [1:0]            sense;
    logic [7:0]            rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [NG*GW-1:0] level;
  logic [NG*GW-1:0] change;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] used_mask(input int g);
    if (g == 3) return pcirq_pkg::MASK3_USED;
    return 8'hff;
  endfunction

  function automatic logic group_present(input int g);
    return LARGE_VARIANT || (g < 2); // [RULE13]
  endfunction

  function automatic logic [7:0] flag_byte(input state_t s);
    logic [7:0] b;
    b = pcirq_pkg::RESET_BYTE;
    for (int g = 0; g < NG; g++) begin
      b[pcirq_pkg::BIT_GROUP0+g] = s.group_flag[g];
    end
    b[pcirq_pkg::BIT_EXT0] = s.ext0_flag;
    return b;
  endfunction

  // ****************************************
  // change detection, output drive does not matter here
  // ****************************************
  pcirq_edge_detect #(
    .WIDTH (NG*GW)
  ) u_edge (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_pins    ({i_change_input_pins, i_ext_irq_pin_zero}),
    .o_level   (level),
    .o_change  (change)
  ); // [RULE17]

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0]             w;
    logic                   ext_event;
    logic                   pin0_now;
    logic                   pin0_prev_hi;
    logic [NG*GW-1:0]       pc_change;
    w            = i_req.wdata;
    ext_event    = 1'b0;
    pin0_now     = level[0];
    pin0_prev_hi = pin0_now ^ change[0];
    pc_change    = {1'b0, change[NG*GW-1:1]};
    state_next   = state_reg;

    if (i_req.wr) begin
      for (int g = 0; g < NG; g++) begin
        if (group_present(g)) begin
          if (i_req.addr == pcirq_pkg::ADDR_MASK0 + 8'(g) && g < 3) begin
            state_next.mask[g] = w;
          end
        end
      end
      if (LARGE_VARIANT && i_req.addr == pcirq_pkg::ADDR_MASK3) begin
        state_next.mask[3] = w & pcirq_pkg::MASK3_USED; // [RULE19]
      end
      if (i_req.addr == pcirq_pkg::ADDR_ENABLE) begin // [RULE15]
        for (int g = 0; g < NG; g++) begin
          state_next.group_enable[g] = w[pcirq_pkg::BIT_GROUP0+g] & group_present(g);
        end
        state_next.ext0_enable = w[pcirq_pkg::BIT_EXT0];
      end
      if (i_req.addr == pcirq_pkg::ADDR_SENSE) begin
        state_next.sense = w[pcirq_pkg::SENSE_WIDTH-1:0];
      end
      if (i_req.addr == pcirq_pkg::ADDR_FLAGS) begin
        for (int g = 0; g < NG; g++) begin
          if (w[pcirq_pkg::BIT_GROUP0+g]) state_next.group_flag[g] = 1'b0; // [RULE6]
        end
        if (w[pcirq_pkg::BIT_EXT0]) state_next.ext0_flag = 1'b0; // [RULE6]
      end
    end

    for (int g = 0; g < NG; g++) begin
      if (i_serviced[g+1]) state_next.group_flag[g] = 1'b0; // [RULE5]
    end
    if (i_serviced[0]) state_next.ext0_flag = 1'b0; // [RULE5]

    // set after clears so an event in the clearing cycle survives
    for (int g = 0; g < NG; g++) begin
      // mask bit gates the pin; group enable only gates the vector
      if (group_present(g) &&
          |(pc_change[g*GW +: GW] & state_reg.mask[g] & used_mask(g))) begin // [RULE12]
        state_next.group_flag[g] = 1'b1; // [RULE1] [RULE2] [RULE8] [RULE9] [RULE10] [RULE11] [RULE16]
      end
    end

    unique case (pcirq_pkg::sense_mode_t'(state_reg.sense)) // [RULE14]
      pcirq_pkg::SENSE_LOW:     ext_event = 1'b0;
      pcirq_pkg::SENSE_CHANGE:  ext_event = change[0];
      pcirq_pkg::SENSE_FALLING: ext_event = change[0] & pin0_prev_hi;
      pcirq_pkg::SENSE_RISING:  ext_event = change[0] & pin0_now;
    endcase
    if (ext_event) state_next.ext0_flag = 1'b1; // [RULE3]
    if (pcirq_pkg::sense_mode_t'(state_next.sense) == pcirq_pkg::SENSE_LOW) begin
      state_next.ext0_flag = 1'b0; // [RULE7]
    end
    for (int g = 0; g < NG; g++) begin
      if (!group_present(g)) state_next.group_flag[g] = 1'b0; // [RULE13]
    end

    state_next.rdata = pcirq_pkg::RESET_BYTE;
    if (i_req.rd) begin
      unique case (i_req.addr)
        pcirq_pkg::ADDR_MASK0:  state_next.rdata = state_reg.mask[0];
        pcirq_pkg::ADDR_MASK1:  state_next.rdata = state_reg.mask[1];
        pcirq_pkg::ADDR_MASK2:  state_next.rdata = state_reg.mask[2];
        pcirq_pkg::ADDR_MASK3:  state_next.rdata = state_reg.mask[3];
        pcirq_pkg::ADDR_SENSE:  state_next.rdata = {6'h00, state_reg.sense};
        pcirq_pkg::ADDR_FLAGS:  state_next.rdata = flag_byte(state_reg);
        pcirq_pkg::ADDR_ENABLE: begin
          state_next.rdata = {state_reg.group_enable, 3'h0, state_reg.ext0_enable};
        end
        default:                state_next.rdata = pcirq_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0; // [RULE19]
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // vector requests
  // ****************************************
  always_comb begin
    o_request[0] = i_global_irq_enable & state_reg.ext0_enable & state_reg.ext0_flag; // [RULE4]
    for (int g = 0; g < NG; g++) begin
      o_request[g+1] = i_global_irq_enable & state_reg.group_enable[g] &
                       state_reg.group_flag[g]; // [RULE4]
    end
  end

  // level sense has no flag: the pin itself stands as the request
  assign o_ext_pin_level_req = i_global_irq_enable & state_reg.ext0_enable &
                               (pcirq_pkg::sense_mode_t'(state_reg.sense) ==
                                pcirq_pkg::SENSE_LOW) & ~level[0];
  assign o_rdata = state_reg.rdata;

endmodule

/* test/pcirq_core_model.sv */
// core-side model: enters the vector of every pending request
// assumes requests are levels; i_hold lets the bench stall servicing
`timescale 1ns/1ps
module pcirq_core_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       i_hold,
  input  wire logic [4:0] i_request,
  output logic      [4:0] o_serviced
);
  // one pulse per entry; masking with the last pulse avoids a double entry
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_serviced <= 5'h00;
    end else if (i_hold) begin
      o_serviced <= 5'h00;
    end else begin
      o_serviced <= i_request & ~o_serviced;
    end
  end
endmodule

/* test/pcirq_flags_assertions.sv */
// checker of the flag block, sees only its ports
// assumes writes that land on the strobe's edge; variant given by parameter
`timescale 1ns/1ps
module pcirq_flags_checker #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_rst,
  input  wire pcirq_pkg::reg_req_t               i_req,
  input  wire logic [7:0]                        o_rdata,
  input  wire logic [pcirq_pkg::NUM_PINS-1:0]    i_change_input_pins,
  input  wire logic                              i_global_irq_enable,
  input  wire logic [pcirq_pkg::NUM_VECTORS-1:0] i_serviced,
  input  wire logic [pcirq_pkg::NUM_VECTORS-1:0] o_request
);
  // the small variant has no enable bits for groups 3 and 2
  localparam logic [7:0] EN_USED = LARGE_VARIANT ? pcirq_pkg::FLAG_USED_BIG :
                                                   pcirq_pkg::FLAG_USED_SMAL;
  logic [7:0] en_q, m0_q, p1, p2, p3;
  logic [1:0] sense_q;
  logic       quiet;
  logic       wr_ok;
  assign wr_ok = i_req.wr;
  // current input equal to three past samples: no group 0 change can be in flight
  assign quiet = (i_change_input_pins[7:0] == p1) && (p1 == p2) && (p2 == p3);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      {en_q, m0_q, p1, p2, p3, sense_q} <= '0;
    end else begin
      {p1, p2, p3} <= {i_change_input_pins[7:0], p1, p2};
      if (wr_ok && i_req.addr == pcirq_pkg::ADDR_ENABLE) en_q <= i_req.wdata & EN_USED;
      if (wr_ok && i_req.addr == pcirq_pkg::ADDR_MASK0) m0_q <= i_req.wdata;
      if (wr_ok && i_req.addr == pcirq_pkg::ADDR_SENSE) sense_q <= i_req.wdata[1:0];
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  AST_REQ_GATE: assert property (o_request != 5'h00 |->
    (i_global_irq_enable || $past(i_global_irq_enable)) && (en_q[0] || !o_request[0])
    && ((o_request[4:1] & ~en_q[7:4]) == 4'h0)) else $error("request without enables");
  AST_LEVEL_FLAG: assert property (sense_q == 2'h0 && $past(sense_q) == 2'h0 |->
    !o_request[0]) else $error("pin zero flag set in level mode");
  AST_SVC_CLEAR: assert property (i_serviced[1] && quiet |=> !o_request[1])
    else $error("group 0 flag kept after service");
  AST_W1C: assert property (wr_ok && i_req.addr == pcirq_pkg::ADDR_FLAGS
    && i_req.wdata[4] && quiet |=> !o_request[1]) else $error("write one did not clear");
  AST_MASK_BLOCK: assert property (!o_request[1] && m0_q == 8'h00
    && $past(m0_q) == 8'h00 && en_q[4] && i_global_irq_enable && $past(i_global_irq_enable)
    |=> !o_request[1]) else $error("masked pin raised a request");
  AST_RESERVED: assert property ($past(i_req.rd) &&
    ($past(i_req.addr) == pcirq_pkg::ADDR_FLAGS || $past(i_req.addr) == pcirq_pkg::ADDR_ENABLE)
    |-> o_rdata[3:1] == 3'h0) else $error("reserved bits not zero");
  AST_MASK3_TOP: assert property ($past(i_req.rd) &&
    $past(i_req.addr) == pcirq_pkg::ADDR_MASK3 |-> !o_rdata[7]) else $error("mask 3 bit 7 set");
  AST_EN_READ: assert property ($past(i_req.rd) &&
    $past(i_req.addr) == pcirq_pkg::ADDR_ENABLE |-> o_rdata == $past(en_q))
    else $error("enable readback wrong");
  COV_SVC: cover property (i_serviced[1] ##1 !o_request[1]);
  COV_EXT: cover property (o_request[0]);
  COV_W1C: cover property (wr_ok && i_req.addr == pcirq_pkg::ADDR_FLAGS);
endmodule
bind pcirq_flags pcirq_flags_checker #(.LARGE_VARIANT(LARGE_VARIANT)) i_chk (.i_clk_sys,
  .i_rst, .i_req, .o_rdata,
  .i_change_input_pins, .i_global_irq_enable, .i_serviced, .o_request);

/* test/tb_top.sv */
// bench of the flag block with a core model
// runs the large and the small variant side by side on shared inputs
// assumes no servicing while hold is high
`timescale 1ns/1ps
module tb_top;
  logic                clk, rst, gie, ext, hold, lvl, lvl_s;
  pcirq_pkg::reg_req_t req;
  logic [7:0]          rdata, rs, rdata_s, rs_s;
  logic [30:0]         pins;
  logic [4:0]          req_v, svc, req_v_s;
  int                  miscompares, comparisons;
  logic [7:0]          madr [4] = '{pcirq_pkg::ADDR_MASK0, pcirq_pkg::ADDR_MASK1,
                                    pcirq_pkg::ADDR_MASK2, pcirq_pkg::ADDR_MASK3};
  localparam logic [7:0] FL = pcirq_pkg::ADDR_FLAGS;
  localparam logic [7:0] EN = pcirq_pkg::ADDR_ENABLE;
  pcirq_flags #(.LARGE_VARIANT(1'b1)) i_pcirq_flags (.i_clk_sys(clk), .i_rst(rst),
    .i_req(req), .o_rdata(rdata), .i_change_input_pins(pins), .i_ext_irq_pin_zero(ext),
    .i_global_irq_enable(gie), .i_serviced(svc), .o_request(req_v), .o_ext_pin_level_req(lvl));
  // small variant shares every input; the core model serves the large one
  pcirq_flags #(.LARGE_VARIANT(1'b0)) i_pcirq_flags_small (.i_clk_sys(clk), .i_rst(rst),
    .i_req(req), .o_rdata(rdata_s), .i_change_input_pins(pins), .i_ext_irq_pin_zero(ext),
    .i_global_irq_enable(gie), .i_serviced(svc), .o_request(req_v_s),
    .o_ext_pin_level_req(lvl_s));
  pcirq_core_model i_pcirq_core_model (.i_clk_sys(clk), .i_rst(rst), .i_hold(hold),
    .i_request(req_v), .o_serviced(svc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= {a, d, 1'b1, 1'b0};
    @(posedge clk) req <= {a, d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) req <= {a, 8'h00, 1'b0, 1'b0};
    #1 rs = rdata;
    rs_s = rdata_s;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic flip(input int n);
    @(posedge clk) pins[n] <= ~pins[n];
    cyc(3);
  endtask
  task automatic t_reset;
    foreach (madr[i]) begin
      rd(madr[i]); chk(rs, 8'h00);
    end
    rd(FL); chk(rs, 8'h00);
    rd(8'h00); chk(rs, 8'h00);
    wr(madr[3], 8'hff); rd(madr[3]); chk(rs, 8'h7f);
    chk(rs_s, 8'h00);
    wr(madr[2], 8'hff); rd(madr[2]); chk(rs_s, 8'h00);
    chk(rs, 8'hff);
    wr(EN, 8'hff); rd(EN); chk(rs, 8'hf1);
    chk(rs_s, 8'h31);
    wr(madr[3], 8'h00); wr(madr[2], 8'h00); wr(EN, 8'h00);
    $display("test reset_values done");
  endtask
  task automatic t_groups;
    for (int g = 0; g < 4; g++) begin
      wr(EN, 8'h10 << g); wr(madr[g], 8'h01); flip(8 * g);
      chk(req_v, 5'h02 << g);
      chk(req_v_s, (g < 2) ? 5'h02 << g : 5'h00);
      rd(FL); chk(rs, 8'h10 << g);
      chk(rs_s, (g < 2) ? 8'h10 << g : 8'h00);
      if (g == 1) begin
        @(posedge clk) gie <= 1'b0;
        cyc(2); chk(req_v, 5'h00);
        @(posedge clk) gie <= 1'b1;
      end
      @(posedge clk) hold <= 1'b0;
      cyc(4); chk(req_v, 5'h00);
      rd(FL); chk(rs, 8'h00);
      @(posedge clk) hold <= 1'b1;
      wr(madr[g], 8'h00);
    end
    $display("test group_flags done");
  endtask
  task automatic t_mask_w1c;
    wr(EN, 8'h10); flip(0);
    rd(FL); chk(rs, 8'h00);
    wr(madr[0], 8'hfe); flip(0);
    rd(FL); chk(rs, 8'h00);
    wr(EN, 8'h00); wr(madr[0], 8'h01); flip(0);
    chk(req_v, 5'h00);
    rd(FL); chk(rs, 8'h10);
    wr(FL, 8'h00); rd(FL); chk(rs, 8'h10);
    wr(FL, 8'h10); rd(FL); chk(rs, 8'h00);
    wr(madr[0], 8'h00);
    $display("test mask_and_clear done");
  endtask
  task automatic t_ext0;
    for (int m = 1; m < 4; m++) begin
      wr(pcirq_pkg::ADDR_SENSE, 8'(m)); wr(EN, 8'h01);
      @(posedge clk) ext <= 1'b1;
      cyc(3); rd(FL); chk(rs, {7'h00, m != 2});
      wr(FL, 8'h01);
      @(posedge clk) ext <= 1'b0;
      cyc(3); rd(FL); chk(rs, {7'h00, m != 3});
      wr(FL, 8'h01);
    end
    wr(pcirq_pkg::ADDR_SENSE, 8'h00);
    cyc(3); chk(lvl, 1'b1);
    chk(lvl_s, 1'b1);
    rd(FL); chk(rs, 8'h00);
    @(posedge clk) ext <= 1'b1;
    cyc(3); chk(lvl, 1'b0);
    rd(FL); chk(rs, 8'h00);
    wr(EN, 8'h00);
    $display("test pin_zero_sense done");
  endtask
  task automatic final_report;
    $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {rst, gie, hold, ext, pins, req} = {3'b111, 1'b0, 31'h0, 18'h0};
    {miscompares, comparisons} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset; t_groups; t_mask_w1c; t_ext0;
    final_report;
  end
  // whole run needs well under 1000 cycles
  initial begin
    #50000;
    miscompares++;
    final_report;
  end
endmodule
